// >>> issue_pkg.sv
// Constants shared by the issue, scoreboard, write-back and crossbar logic.
// Assumes a single core clock and one decoder feeding one instruction slot.
package issue_pkg;
  localparam int REG_COUNT = 64;
  localparam int REG_IDX_W = 6;
  localparam logic [REG_IDX_W-1:0] ZERO_REG = 6'h00;
  localparam int SRC_PORTS = 3;
  localparam int WB_BUSES = 2;
  localparam int WORD_W = 64;
  localparam int TAG_W = 8;
  localparam int READ_CYCLES = 2;
  localparam logic [REG_COUNT-1:0] BUSY_RESET = 64'h0000000000000000;

  // Immediate width codes
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2,
    SZ_FULL = 2'h3
  } imm_size_e;
endpackage

// >>> oldest_arbiter.sv
// Picks up to NBUS pending results by age for the register write buses.
// Assumes fewer than 2**TAG_W instructions in flight so ages do not alias.
module oldest_arbiter
  import issue_pkg::*;
#(
  parameter int NRES = 4,
  parameter int NBUS = 2,
  parameter int TW = 8
) (
  input wire logic [NRES-1:0] req,
  input wire logic [NRES-1:0][TW-1:0] tag,
  input wire logic [TW-1:0] next_tag,
  output logic [NRES-1:0] grant,
  output logic [NBUS-1:0] bus_v,
  output logic [NBUS-1:0][$clog2(NRES)-1:0] bus_sel
);
  localparam int IW = $clog2(NRES);

  // Age is distance back from the next tag to be handed out
  function automatic logic older(input logic [TW-1:0] ta, input logic [TW-1:0] tb,
                                 input int ia, input int ib);
    logic [TW-1:0] aa;
    logic [TW-1:0] ab;
    aa = next_tag - ta;
    ab = next_tag - tb;
    older = (aa > ab) || ((aa == ab) && (ia < ib));
  endfunction

  // Rank each request by how many valid requests are older
  always_comb begin
    int rank;
    rank = 0;
    grant = '0;
    bus_v = '0;
    bus_sel = '0;
    for (int i = 0; i < NRES; i++) begin
      rank = 0;
      for (int j = 0; j < NRES; j++) begin
        if (j != i && req[j] && older(tag[j], tag[i], j, i)) begin
          rank = rank + 1;
        end
      end
      if (req[i] && rank < NBUS) begin
        grant[i] = 1'b1;
        bus_v[rank] = 1'b1;
        bus_sel[rank] = IW'(i);
      end
    end
  end
endmodule

// >>> issue_scoreboard_writeback_xbar.sv
// Issue control: decode hold slot, busy scoreboard, two write buses, crossbar.
// Assumes execution units return each result with the tag it was issued with.
module issue_scoreboard_writeback_xbar
  import issue_pkg::*;
#(
  parameter int WIDTH = WORD_W,
  parameter int NRES = 4,
  parameter int OP_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic dec_valid,
  input wire logic [OP_W-1:0] dec_op,
  input wire logic [SRC_PORTS-1:0][REG_IDX_W-1:0] dec_src,
  input wire logic [SRC_PORTS-1:0] dec_src_en,
  input wire logic [REG_IDX_W-1:0] dec_dst,
  input wire logic dec_dst_en,
  input wire logic [WIDTH-1:0] dec_imm,
  input wire logic dec_imm_en,
  input wire logic [1:0] dec_imm_size,
  output logic dec_ready_q,
  output logic op_valid_q,
  output logic [OP_W-1:0] op_code_q,
  output logic [REG_IDX_W-1:0] op_dst_q,
  output logic op_dst_en_q,
  output logic [TAG_W-1:0] op_tag_q,
  output logic [SRC_PORTS-1:0][WIDTH-1:0] op_data_q,
  input wire logic [NRES-1:0] res_valid,
  input wire logic [NRES-1:0][REG_IDX_W-1:0] res_reg,
  input wire logic [NRES-1:0][WIDTH-1:0] res_data,
  input wire logic [NRES-1:0][TAG_W-1:0] res_tag,
  output logic [NRES-1:0] res_ready_q,
  output logic [WB_BUSES-1:0] wb_v_q,
  output logic [WB_BUSES-1:0][REG_IDX_W-1:0] wb_reg_q,
  output logic [WB_BUSES-1:0][WIDTH-1:0] wb_data_q,
  output logic [WB_BUSES-1:0] wb_zero_q
);
  localparam int IW = $clog2(NRES);

  initial begin
    if (WIDTH < 64 || NRES < WB_BUSES || NRES > (1 << TAG_W)) begin
      $error("issue block: unsupported WIDTH or NRES");
    end
  end

  // Register file busy flags live here only, no software path
  logic [WIDTH-1:0] rf_mem [REG_COUNT];
  logic [REG_COUNT-1:0] busy_q;
  logic [TAG_W-1:0] iss_cnt_q;

  // Decode hold slot
  logic h_v_q;
  logic [OP_W-1:0] h_op_q;
  logic [SRC_PORTS-1:0][REG_IDX_W-1:0] h_src_q;
  logic [SRC_PORTS-1:0] h_src_en_q;
  logic [REG_IDX_W-1:0] h_dst_q;
  logic h_dst_en_q;
  logic [WIDTH-1:0] h_imm_q;
  logic h_imm_en_q;
  logic [1:0] h_imm_size_q;

  // Read stage (register file cycle)
  logic s1_v_q;
  logic [OP_W-1:0] s1_op_q;
  logic [REG_IDX_W-1:0] s1_dst_q;
  logic s1_dst_en_q;
  logic [TAG_W-1:0] s1_tag_q;
  logic [SRC_PORTS-1:0][WIDTH-1:0] s1_data_q;

  // Result holding slots, one per execution unit port
  logic [NRES-1:0] slot_v_q;
  logic [NRES-1:0][REG_IDX_W-1:0] slot_reg_q;
  logic [NRES-1:0][WIDTH-1:0] slot_data_q;
  logic [NRES-1:0][TAG_W-1:0] slot_tag_q;
  logic [NRES-1:0] grant;
  logic [NRES-1:0] slot_v_d;
  logic [WB_BUSES-1:0] bus_v;
  logic [WB_BUSES-1:0][IW-1:0] bus_sel;
  logic [REG_COUNT-1:0] clear_now;
  logic stall;
  logic issue;

  // A register counts as busy unless its result is on a bus this cycle
  function automatic logic reg_busy(input logic [REG_IDX_W-1:0] idx,
                                    input logic [REG_COUNT-1:0] bsy,
                                    input logic [REG_COUNT-1:0] clr);
    reg_busy = bsy[idx] && !clr[idx];
  endfunction

  // Crossbar read: zero register, write-bus bypass, else register file
  function automatic logic [WIDTH-1:0] xbar_read(input logic [REG_IDX_W-1:0] idx);
    logic [WIDTH-1:0] val;
    val = rf_mem[idx];
    for (int b = 0; b < WB_BUSES; b++) begin
      if (wb_v_q[b] && wb_reg_q[b] == idx) begin
        val = wb_data_q[b];
      end
    end
    if (idx == ZERO_REG) begin
      val = '0;
    end
    xbar_read = val;
  endfunction

  // Immediate formatting to the selected width
  function automatic logic [WIDTH-1:0] imm_fmt(input logic [WIDTH-1:0] v,
                                               input logic [1:0] sz);
    logic [WIDTH-1:0] r;
    r = v;
    unique case (imm_size_e'(sz))
      SZ_BYTE: r = {{(WIDTH-8){1'b0}}, v[7:0]};
      SZ_HALF: r = {{(WIDTH-16){1'b0}}, v[15:0]};
      SZ_WORD: r = {{(WIDTH-32){1'b0}}, v[31:0]};
      SZ_FULL: r = v;
    endcase
    imm_fmt = r;
  endfunction

  // Registers freed by this cycle's write buses
  always_comb begin
    clear_now = '0;
    for (int b = 0; b < WB_BUSES; b++) begin
      if (wb_v_q[b]) begin
        clear_now[wb_reg_q[b]] = 1'b1;
      end
    end
  end

  // Single check on every read and written register; WAW falls out
  always_comb begin
    stall = h_dst_en_q && reg_busy(h_dst_q, busy_q, clear_now);
    for (int s = 0; s < SRC_PORTS; s++) begin
      if (h_src_en_q[s] && reg_busy(h_src_q[s], busy_q, clear_now)) begin
        stall = 1'b1;
      end
    end
  end
  assign issue = h_v_q && !stall;

  // Decode hold slot: takes one instruction, releases it in order
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      h_v_q <= 1'b0;
      dec_ready_q <= 1'b0;
      h_op_q <= '0;
      h_src_q <= '0;
      h_src_en_q <= '0;
      h_dst_q <= '0;
      h_dst_en_q <= 1'b0;
      h_imm_q <= '0;
      h_imm_en_q <= 1'b0;
      h_imm_size_q <= 2'h0;
    end else begin
      if (dec_valid && dec_ready_q) begin
        h_v_q <= 1'b1;
        h_op_q <= dec_op;
        h_src_q <= dec_src;
        h_src_en_q <= dec_src_en;
        h_dst_q <= dec_dst;
        h_dst_en_q <= dec_dst_en;
        h_imm_q <= dec_imm;
        h_imm_en_q <= dec_imm_en;
        h_imm_size_q <= dec_imm_size;
      end else if (issue) begin
        h_v_q <= 1'b0;
      end
      dec_ready_q <= !(dec_valid && dec_ready_q) && !(h_v_q && stall);
    end
  end

  // Scoreboard: set at issue wins over a clear of the same register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_q <= BUSY_RESET;
      iss_cnt_q <= '0;
    end else begin
      for (int r = 0; r < REG_COUNT; r++) begin
        if (issue && h_dst_en_q && h_dst_q == REG_IDX_W'(r) && r != 0) begin
          busy_q[r] <= 1'b1;
        end else if (clear_now[r]) begin
          busy_q[r] <= 1'b0;
        end
      end
      if (issue) begin
        iss_cnt_q <= iss_cnt_q + 1'b1;
      end
    end
  end

  // Read stage: three sources through crossbar, immediate replaces second
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_v_q <= 1'b0;
      s1_op_q <= '0;
      s1_dst_q <= '0;
      s1_dst_en_q <= 1'b0;
      s1_tag_q <= '0;
      s1_data_q <= '0;
    end else begin
      s1_v_q <= issue;
      if (issue) begin
        s1_op_q <= h_op_q;
        s1_dst_q <= h_dst_q;
        s1_dst_en_q <= h_dst_en_q;
        s1_tag_q <= iss_cnt_q;
        for (int s = 0; s < SRC_PORTS; s++) begin
          s1_data_q[s] <= h_src_en_q[s] ? xbar_read(h_src_q[s]) : '0;
        end
        if (h_imm_en_q) begin
          s1_data_q[1] <= imm_fmt(h_imm_q, h_imm_size_q);
        end
      end
    end
  end

  // Crossbar stage drives the execution unit inputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      op_valid_q <= 1'b0;
      op_code_q <= '0;
      op_dst_q <= '0;
      op_dst_en_q <= 1'b0;
      op_tag_q <= '0;
      op_data_q <= '0;
    end else begin
      op_valid_q <= s1_v_q;
      op_code_q <= s1_op_q;
      op_dst_q <= s1_dst_q;
      op_dst_en_q <= s1_dst_en_q;
      op_tag_q <= s1_tag_q;
      op_data_q <= s1_data_q;
    end
  end

  // Each unit port owns a slot, so a slow unit holds only its own
  assign slot_v_d = (slot_v_q & ~grant) | (res_valid & res_ready_q);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slot_v_q <= '0;
      slot_reg_q <= '0;
      slot_data_q <= '0;
      slot_tag_q <= '0;
      res_ready_q <= '0;
    end else begin
      slot_v_q <= slot_v_d;
      res_ready_q <= ~slot_v_d;
      for (int i = 0; i < NRES; i++) begin
        if (res_valid[i] && res_ready_q[i]) begin
          slot_reg_q[i] <= res_reg[i];
          slot_data_q[i] <= res_data[i];
          slot_tag_q[i] <= res_tag[i];
        end
      end
    end
  end

  oldest_arbiter #(.NRES(NRES), .NBUS(WB_BUSES), .TW(TAG_W)) arb (
    .req(slot_v_q),
    .tag(slot_tag_q),
    .next_tag(iss_cnt_q),
    .grant(grant),
    .bus_v(bus_v),
    .bus_sel(bus_sel)
  );

  // Write buses with zero test; results for register zero are dropped
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wb_v_q <= '0;
      wb_reg_q <= '0;
      wb_data_q <= '0;
      wb_zero_q <= '0;
    end else begin
      for (int b = 0; b < WB_BUSES; b++) begin
        wb_v_q[b] <= bus_v[b] && slot_reg_q[bus_sel[b]] != ZERO_REG;
        wb_reg_q[b] <= slot_reg_q[bus_sel[b]];
        wb_data_q[b] <= slot_data_q[bus_sel[b]];
        wb_zero_q[b] <= bus_v[b] && slot_data_q[bus_sel[b]] == '0;
      end
    end
  end

  // Register file written from both buses in the same cycle
  always_ff @(posedge ref_clk) begin
    for (int b = 0; b < WB_BUSES; b++) begin
      if (wb_v_q[b]) begin
        rf_mem[wb_reg_q[b]] <= wb_data_q[b];
      end
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  read_latency_a: assert property (issue |=> s1_v_q ##1 op_valid_q)
    else $error("operands not presented two cycles after issue");
  zero_never_busy_a: assert property (!busy_q[0])
    else $error("register zero marked busy");
  busy_set_a: assert property (issue && h_dst_en_q && h_dst_q != ZERO_REG
    |=> busy_q[$past(h_dst_q)])
    else $error("destination not marked busy at issue");
  stall_hold_a: assert property (h_v_q && h_dst_en_q && busy_q[h_dst_q]
    && !clear_now[h_dst_q] |=> h_v_q && !s1_v_q)
    else $error("instruction left decode while its register was busy");
  busy_clear_a: assert property (wb_v_q[0] && !(issue && h_dst_en_q
    && h_dst_q == wb_reg_q[0]) |=> !busy_q[$past(wb_reg_q[0])])
    else $error("busy flag not cleared at write-back");
  two_bus_a: assert property ($countones(slot_v_q) >= 2
    |-> $countones(grant) == 2)
    else $error("two pending results not both granted");
  lone_result_a: assert property ($countones(slot_v_q) == 1
    |=> !$past(grant[0]) || !slot_v_q[0] || $past(res_valid[0]))
    else $error("granted lone result still pending");
  order_a: assert property (op_valid_q && $past(op_valid_q)
    |-> op_tag_q == TAG_W'($past(op_tag_q) + 1'b1))
    else $error("issue out of program order");
  zero_read_a: assert property (issue && h_src_en_q[0] && !h_imm_en_q
    && h_src_q[0] == ZERO_REG |=> ##1 op_data_q[0] == '0)
    else $error("zero register read as nonzero");
  bypass_a: assert property (issue && h_src_en_q[2] && wb_v_q[0]
    && wb_reg_q[0] == h_src_q[2] |=> s1_data_q[2] == $past(wb_data_q[0]))
    else $error("result on write bus not forwarded");
  imm_byte_a: assert property (issue && h_imm_en_q && h_imm_size_q == SZ_BYTE
    |=> s1_data_q[1][WIDTH-1:8] == '0)
    else $error("byte immediate not zero extended");

  back_to_back_c: cover property (op_valid_q ##1 op_valid_q);
  dual_write_c: cover property (wb_v_q == 2'b11);
  bypass_c: cover property (issue && wb_v_q[0] && h_src_en_q[0]
    && wb_reg_q[0] == h_src_q[0]);
  stall_c: cover property (h_v_q && stall ##1 issue);
endmodule

// >>> exec_units_model.sv
// Behavioural execution units, one operation slot per result port.
// Assumes op_code bits 1:0 pick the port and bits 7:4 the latency (1..15).
module exec_units_model
  import issue_pkg::*;
#(
  parameter int NRES = 4,
  parameter int WIDTH = WORD_W,
  parameter int OP_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic op_valid_q,
  input wire logic [OP_W-1:0] op_code_q,
  input wire logic [REG_IDX_W-1:0] op_dst_q,
  input wire logic [TAG_W-1:0] op_tag_q,
  input wire logic [SRC_PORTS-1:0][WIDTH-1:0] op_data_q,
  input wire logic [NRES-1:0] res_ready_q,
  output logic [NRES-1:0] res_valid,
  output logic [NRES-1:0][REG_IDX_W-1:0] res_reg,
  output logic [NRES-1:0][WIDTH-1:0] res_data,
  output logic [NRES-1:0][TAG_W-1:0] res_tag
);
  logic [NRES-1:0][3:0] cnt_q;
  logic [NRES-1:0][WIDTH-1:0] sum_q;

  // Run each unit's latency down, then offer the sum until taken
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      res_valid <= '0;
      sum_q <= '0;
      res_reg <= '0;
      res_tag <= '0;
    end else begin
      for (int p = 0; p < NRES; p++) begin
        if (res_valid[p] && res_ready_q[p]) res_valid[p] <= 1'h0;
        if (cnt_q[p] != 4'h0) cnt_q[p] <= cnt_q[p] - 4'h1;
        if (cnt_q[p] == 4'h1) res_valid[p] <= 1'h1;
        if (op_valid_q && op_code_q[1:0] == p[1:0]) begin
          cnt_q[p] <= op_code_q[7:4];
          res_reg[p] <= op_dst_q;
          res_tag[p] <= op_tag_q;
          sum_q[p] <= op_data_q[0] + op_data_q[1] + op_data_q[2];
        end
      end
    end
  end

  // Idle data lines show the inverse of the last sum
  always_comb
    for (int p = 0; p < NRES; p++)
      res_data[p] = res_valid[p] ? sum_q[p] : ~sum_q[p];
endmodule

// >>> issue_scoreboard_writeback_xbar_bench.sv
// Self-checking bench for the issue, scoreboard and write-back block.
// Assumes exec_units_model on the result side and default parameters.
module issue_scoreboard_writeback_xbar_bench;
  import issue_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 3000;
  localparam logic [63:0] IMM = 64'hFEDCBA9876543210;
  localparam logic [63:0] MSK [4] = '{64'hFF, 64'hFFFF, 64'hFFFFFFFF,
    64'hFFFFFFFFFFFFFFFF};
  typedef struct packed {logic [31:0] c; logic [2:0][63:0] d;} op_rec_s;
  typedef struct packed {
    logic [31:0] c; logic b; logic z; logic [5:0] r; logic [63:0] d;
  } wr_rec_s;
  logic ref_clk, rst, dec_valid, dec_dst_en, dec_imm_en, dec_ready_q;
  logic op_valid_q, op_dst_en_q;
  logic [7:0] dec_op, op_code_q;
  logic [SRC_PORTS-1:0][REG_IDX_W-1:0] dec_src;
  logic [SRC_PORTS-1:0] dec_src_en;
  logic [REG_IDX_W-1:0] dec_dst, op_dst_q;
  logic [WORD_W-1:0] dec_imm;
  logic [1:0] dec_imm_size;
  logic [TAG_W-1:0] op_tag_q;
  logic [SRC_PORTS-1:0][WORD_W-1:0] op_data_q;
  logic [3:0] res_valid, res_ready_q;
  logic [3:0][REG_IDX_W-1:0] res_reg;
  logic [3:0][WORD_W-1:0] res_data;
  logic [3:0][TAG_W-1:0] res_tag;
  logic [WB_BUSES-1:0] wb_v_q, wb_zero_q;
  logic [WB_BUSES-1:0][REG_IDX_W-1:0] wb_reg_q;
  logic [WB_BUSES-1:0][WORD_W-1:0] wb_data_q;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int take_c = 0;
  op_rec_s oq[$];
  wr_rec_s wq[$];

  issue_scoreboard_writeback_xbar uut (.ref_clk, .rst, .dec_valid, .dec_op,
    .dec_src, .dec_src_en, .dec_dst, .dec_dst_en, .dec_imm, .dec_imm_en,
    .dec_imm_size, .dec_ready_q, .op_valid_q, .op_code_q, .op_dst_q,
    .op_dst_en_q, .op_tag_q, .op_data_q, .res_valid, .res_reg, .res_data,
    .res_tag, .res_ready_q, .wb_v_q, .wb_reg_q, .wb_data_q, .wb_zero_q);
  exec_units_model units (.ref_clk, .rst, .op_valid_q, .op_code_q, .op_dst_q,
    .op_tag_q, .op_data_q, .res_ready_q, .res_valid, .res_reg, .res_data,
    .res_tag);

  // Clock
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Cycle count and hang limit
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      results();
    end
  end

  // Record issued operations and write-bus traffic mid-cycle
  always @(negedge ref_clk) begin
    if (op_valid_q === 1'h1) oq.push_back('{cyc, op_data_q});
    for (int b = 0; b < WB_BUSES; b++)
      if (wb_v_q[b] === 1'h1)
        wq.push_back('{cyc, b[0], wb_zero_q[b], wb_reg_q[b], wb_data_q[b]});
  end

  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Offer one instruction and hold it until the slot takes it
  task automatic issue(input logic [7:0] op, input logic [17:0] s,
      input logic [5:0] d, input logic ie, input logic [63:0] imm);
    @(posedge ref_clk);
    #1;
    dec_op = op;
    dec_src = s;
    dec_dst = d;
    dec_imm_en = ie;
    dec_imm = imm;
    dec_valid = 1'h1;
    for (int k = 0; k < 200 && dec_ready_q !== 1'h1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    #1;
    take_c = cyc;
    dec_valid = 1'h0;
  endtask

  task automatic get_op(output op_rec_s r);
    for (int k = 0; k < 300 && oq.size() == 0; k++) @(posedge ref_clk);
    chk(72'(oq.size() != 0), 72'h1);
    if (oq.size() != 0) r = oq.pop_front();
  endtask

  task automatic get_wr(output wr_rec_s r);
    for (int k = 0; k < 300 && wq.size() == 0; k++) @(posedge ref_clk);
    chk(72'(wq.size() != 0), 72'h1);
    if (wq.size() != 0) r = wq.pop_front();
  endtask

  // Immediate widths, zero register, read latency, three-source read
  task automatic t_imm;
    op_rec_s o;
    wr_rec_s w;
    logic [5:0] dst [4] = '{6'h01, 6'h02, 6'h03, 6'h3F};
    for (int z = 0; z < 4; z++) begin
      dec_imm_size = z[1:0];
      issue(8'h10, 18'h0, dst[z], 1'h1, IMM);
      get_op(o);
      chk(o.d[1], IMM & MSK[z]);
      chk(o.d[0] | o.d[2], 72'h0);
      chk(72'(o.c - take_c), 72'h2);
      get_wr(w);
      chk({w.r, w.d}, {dst[z], IMM & MSK[z]});
    end
    issue(8'h11, {6'h3F, 6'h02, 6'h01}, 6'h04, 1'h0, 64'h0);
    get_op(o);
    chk({o.d[1][15:0], o.d[0][7:0]}, 72'h321010);
    chk(o.d[2], IMM);
    get_wr(w);
  endtask

  // Slow op outstanding while a fast one writes; dependent op waits
  task automatic t_stall;
    op_rec_s o;
    wr_rec_s w1, w2, w3;
    issue(8'hF3, 18'h0, 6'h09, 1'h1, 64'h11);
    issue(8'h11, 18'h0, 6'h0A, 1'h1, 64'h22);
    issue(8'h12, {6'h00, 6'h09, 6'h0A}, 6'h0B, 1'h0, 64'h0);
    get_op(o);
    get_op(o);
    get_wr(w1);
    get_wr(w2);
    get_op(o);
    get_wr(w3);
    chk({w1.r, w2.r}, {6'h0A, 6'h09});
    chk(72'(o.c > w2.c && o.c <= w2.c + 3), 72'h1);
    chk({o.d[1][7:0], o.d[0][7:0]}, 72'h1122);
    chk({w3.r, w3.d}, {6'h0B, 64'h33});
  endtask

  // Second write to a busy register waits for the first
  task automatic t_waw;
    op_rec_s o;
    wr_rec_s w1, w2;
    issue(8'hA3, 18'h0, 6'h0C, 1'h1, 64'h5);
    issue(8'h10, 18'h0, 6'h0C, 1'h1, 64'h6);
    get_op(o);
    get_op(o);
    get_wr(w1);
    get_wr(w2);
    chk({w1.d[7:0], w2.d[7:0]}, 72'h0506);
  endtask

  // Three results offered together: two oldest first, youngest after
  task automatic t_arb;
    op_rec_s o;
    wr_rec_s w1, w2, w3;
    issue(8'h50, 18'h0, 6'h0D, 1'h1, 64'hA);
    issue(8'h31, 18'h0, 6'h0E, 1'h1, 64'hB);
    issue(8'h12, 18'h0, 6'h0F, 1'h1, 64'h0);
    repeat (3) get_op(o);
    get_wr(w1);
    get_wr(w2);
    get_wr(w3);
    chk({w1.b, w1.r, w2.b, w2.r}, {1'h0, 6'h0D, 1'h1, 6'h0E});
    chk(72'(w1.c == w2.c && w3.c > w1.c), 72'h1);
    chk({w3.r, w3.z, w1.z, w2.z}, {6'h0F, 3'h4});
  endtask

  // Reset in mid-flight leaves no register busy
  task automatic t_reset;
    op_rec_s o;
    issue(8'hF3, 18'h0, 6'h14, 1'h1, 64'h7);
    get_op(o);
    #1;
    rst = 1'h1;
    #1;
    chk({dec_ready_q, wb_v_q, res_valid}, 72'h0);
    repeat (8) @(posedge ref_clk);
    #1;
    rst = 1'h0;
    issue(8'h10, {12'h0, 6'h14}, 6'h15, 1'h0, 64'h0);
    get_op(o);
    chk(72'(o.c - take_c), 72'h2);
  endtask

  // Main sequence
  initial begin
    rst = 1'h1;
    dec_valid = 1'h0;
    dec_op = 8'h0;
    dec_src = '0;
    dec_src_en = 3'h7;
    dec_dst = 6'h0;
    dec_dst_en = 1'h1;
    dec_imm = 64'h0;
    dec_imm_en = 1'h0;
    dec_imm_size = SZ_FULL;
    repeat (8) @(posedge ref_clk);
    #1;
    rst = 1'h0;
    t_imm();
    dec_imm_size = SZ_FULL;
    t_stall();
    t_waw();
    t_arb();
    t_reset();
    results();
  end
endmodule
